// ===== hw/led_seq_pkg.sv
package led_seq_pkg;

	// String count and clock rate.
	localparam int NUM_STRINGS = 4;
	localparam int CLK_MHZ     = 250;
	localparam int CNT_W       = 9;

	// Switching rates, in kHz.
	localparam int F_LOW_KHZ  = 625;
	localparam int F_HIGH_KHZ = 1250;

	// Switching periods in clock cycles, derived from the rates.
	localparam logic [CNT_W-1:0] PER_LOW_CYC  = CNT_W'((CLK_MHZ * 1000) / F_LOW_KHZ);
	localparam logic [CNT_W-1:0] PER_HIGH_CYC = CNT_W'((CLK_MHZ * 1000) / F_HIGH_KHZ);

	// Minimum on-time; a least time, so it rounds up.
	localparam int MIN_ON_NS = 100;
	localparam logic [CNT_W-1:0] MIN_ON_CYC = CNT_W'((MIN_ON_NS * CLK_MHZ + 999) / 1000);

	// Short fault interval in microseconds and in cycles.
	localparam int FAULT_TIME_US = 1600;
	localparam int FAULT_CYC     = FAULT_TIME_US * CLK_MHZ;

	// Soft-start on-time ceiling: starting value and growth per period.
	localparam logic [CNT_W-1:0] SOFT_START_CYC = MIN_ON_CYC;
	localparam logic [CNT_W-1:0] SOFT_INC_CYC   = 9'h004;

	// Positions of the single-bit inputs, and of the first string sense bit (SB_OPEN), in the synchronised vector.
	localparam int SB_ENABLE = 0;
	localparam int SB_FREQ   = 1;
	localparam int SB_DIM    = 2;
	localparam int SB_SUPPLY = 3;
	localparam int SB_TEMP   = 4;
	localparam int SB_OVLOW  = 5;
	localparam int SB_OVTRIP = 6;
	localparam int SB_PEAK   = 7;
	localparam int SB_SKIP   = 8;
	localparam int SB_OPEN   = 9;

	// Sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DIODE,
		ST_SUPPLY,
		ST_TEMP,
		ST_SOFT,
		ST_RUN,
		ST_NODIODE,
		ST_STOP
	} seq_state_t;

endpackage : led_seq_pkg

// ===== hw/sync2.sv
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_r;

	// Two flops in series; only the second stage is ever read.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : sync2

`default_nettype wire

// ===== hw/short_fault_timer.sv
`timescale 1ns/1ps
`default_nettype none

module short_fault_timer #(
	parameter int LIMIT = 400000,
	parameter int TW    = 19
) (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic restart,
	input  wire logic short_det,
	output logic      expired
);

	localparam logic [TW-1:0] LAST = TW'(LIMIT - 1);

	logic [TW-1:0] cnt_r;
	logic [TW-1:0] cnt_nxt;
	wire           hold_on = short_det && !restart;

	if (LIMIT < 2 || LIMIT >= 2 ** TW) begin : g_bad_limit
		$error("short_fault_timer: LIMIT does not fit TW");
	end

	// A gap in the short condition starts the interval again from zero.
	assign cnt_nxt = !hold_on ? '0 : (cnt_r == LAST) ? cnt_r : cnt_r + 1'b1;

	// Expiry is a level while the short keeps going past the interval.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cnt_r   <= '0;
			expired <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			expired <= hold_on && (cnt_r == LAST);
		end
	end

	a_timer_restart: assert property (@(posedge mclk) disable iff (sys_rst)
		!short_det |=> (cnt_r == '0) && !expired)
		else $error("short timer did not restart");

endmodule : short_fault_timer

`default_nettype wire

// ===== hw/led_boost_fault_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Low overvoltage sense at enable: stay disabled.
// - Then check supply, then temperature.
// - All good: start switching through soft-start.
// - Supply lockout holds everything off until recovery.
// - Frequency select low: slow rate, else fast.
// - Switch on each period, off at peak.
// - Pulse skipping with minimum on-time pulses.
// - Feedback only from strings not marked off.
// - Dimming input gates all active strings together.
// - At overvoltage, mark off open strings.
// - All strings open: stop the converter.
// - Marks held until shutdown or restart.
// - Sense above short threshold flags candidate.
// - Short lasting past timer marks string off.
// - Shorted string off and out of feedback.
// - All strings shorted: stop the converter.

module led_boost_fault_sequencer #(
	parameter int NUM_STR   = led_seq_pkg::NUM_STRINGS,
	parameter int FAULT_CYC = led_seq_pkg::FAULT_CYC
) (
	input  wire logic               mclk,
	input  wire logic               sys_rst,
	input  wire logic               enable_pin,
	input  wire logic               freq_select,
	input  wire logic               dim_in,
	input  wire logic               supply_lockout_ok,
	input  wire logic               temp_ok,
	input  wire logic               overvoltage_sense_low,
	input  wire logic               overvoltage_sense_trip,
	input  wire logic [NUM_STR-1:0] string_sense_open,
	input  wire logic [NUM_STR-1:0] string_sense_short,
	input  wire logic               peak_current_trip,
	input  wire logic               skip_request,
	output logic                    switch_on,
	output logic      [NUM_STR-1:0] string_on,
	output logic      [NUM_STR-1:0] feedback_mask,
	output logic      [NUM_STR-1:0] short_candidate,
	output logic      [NUM_STR-1:0] marked_open,
	output logic      [NUM_STR-1:0] marked_short,
	output logic                    converter_active,
	output logic                    soft_start_busy,
	output logic                    diode_missing
);

	localparam int CW = led_seq_pkg::CNT_W;
	localparam int SW = led_seq_pkg::SB_OPEN + 2 * NUM_STR;
	localparam int TW = $clog2(FAULT_CYC + 1);
	localparam logic [CW-1:0] MIN_ON = led_seq_pkg::MIN_ON_CYC;

	if (NUM_STR < 1 || FAULT_CYC < 2) begin : g_bad_params
		$error("led_boost_fault_sequencer: NUM_STR or FAULT_CYC out of range");
	end

	// Period length for the selected rate.
	function automatic logic [CW-1:0] period_len(input logic fast);
		period_len = fast ? led_seq_pkg::PER_HIGH_CYC : led_seq_pkg::PER_LOW_CYC;
	endfunction : period_len

	// Every input is a pin or an analog comparator, so all of them are resynchronised.
	wire  [SW-1:0] raw_in = {string_sense_short, string_sense_open, skip_request,
	                         peak_current_trip, overvoltage_sense_trip,
	                         overvoltage_sense_low, temp_ok, supply_lockout_ok,
	                         dim_in, freq_select, enable_pin};
	logic [SW-1:0] sync_in;

	sync2 #(
		.W(SW)
	) u_sync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.async_in(raw_in),
		.sync_out(sync_in)
	);

	wire               en_s     = sync_in[led_seq_pkg::SB_ENABLE];
	wire               fast_s   = sync_in[led_seq_pkg::SB_FREQ];
	wire               dim_s    = sync_in[led_seq_pkg::SB_DIM];
	wire               supply_s = sync_in[led_seq_pkg::SB_SUPPLY];
	wire               temp_s   = sync_in[led_seq_pkg::SB_TEMP];
	wire               ovlow_s  = sync_in[led_seq_pkg::SB_OVLOW];
	wire               ovtrip_s = sync_in[led_seq_pkg::SB_OVTRIP];
	wire               peak_s   = sync_in[led_seq_pkg::SB_PEAK];
	wire               skip_s   = sync_in[led_seq_pkg::SB_SKIP];
	wire [NUM_STR-1:0] open_s   = sync_in[led_seq_pkg::SB_OPEN +: NUM_STR];
	wire [NUM_STR-1:0] short_s  = sync_in[led_seq_pkg::SB_OPEN + NUM_STR +: NUM_STR];

	led_seq_pkg::seq_state_t state_r;
	led_seq_pkg::seq_state_t state_nxt;

	logic [CW-1:0]      per_cnt_r;
	logic [CW-1:0]      per_cnt_nxt;
	logic [CW-1:0]      on_cnt_r;
	logic [CW-1:0]      on_cnt_nxt;
	logic [CW-1:0]      soft_lim_r;
	logic [CW-1:0]      soft_lim_nxt;
	logic               switch_nxt;
	logic [NUM_STR-1:0] mark_open_r;
	logic [NUM_STR-1:0] mark_open_nxt;
	logic [NUM_STR-1:0] mark_short_r;
	logic [NUM_STR-1:0] mark_short_nxt;
	logic [NUM_STR-1:0] short_exp;

	// Status decode shared by the sequencer, the marks and the outputs.
	wire [CW-1:0]      per_len    = period_len(fast_s);
	wire               per_wrap   = per_cnt_r >= per_len - 1'b1;
	wire               per_late   = per_cnt_r >= per_len - 2'h2;
	wire               switching  = (state_r == led_seq_pkg::ST_SOFT) ||
	                                (state_r == led_seq_pkg::ST_RUN);
	wire               run_ok     = switching && en_s && supply_s;
	wire [NUM_STR-1:0] active     = ~(mark_open_r | mark_short_r);
	wire               all_open   = &mark_open_r;
	wire               all_short  = &mark_short_r;
	wire               none_left  = (active == '0) || all_open || all_short;
	wire               clear_all  = (state_r == led_seq_pkg::ST_IDLE);
	wire [CW:0]        soft_sum   = {1'b0, soft_lim_r} + {1'b0, led_seq_pkg::SOFT_INC_CYC};
	wire               soft_done  = soft_lim_r >= per_len;

	// Start-up sequence; disable and supply lockout override every state.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			led_seq_pkg::ST_IDLE: begin
				state_nxt = led_seq_pkg::ST_DIODE;
			end
			led_seq_pkg::ST_DIODE: begin
				state_nxt = ovlow_s ? led_seq_pkg::ST_NODIODE : led_seq_pkg::ST_SUPPLY;
			end
			led_seq_pkg::ST_SUPPLY: begin
				state_nxt = led_seq_pkg::ST_TEMP;
			end
			led_seq_pkg::ST_TEMP: begin
				if (temp_s) begin
					state_nxt = led_seq_pkg::ST_SOFT;
				end
			end
			led_seq_pkg::ST_SOFT: begin
				if (none_left) begin
					state_nxt = led_seq_pkg::ST_STOP;
				end else if (!temp_s) begin
					state_nxt = led_seq_pkg::ST_TEMP;
				end else if (soft_done) begin
					state_nxt = led_seq_pkg::ST_RUN;
				end
			end
			led_seq_pkg::ST_RUN: begin
				if (none_left) begin
					state_nxt = led_seq_pkg::ST_STOP;
				end else if (!temp_s) begin
					state_nxt = led_seq_pkg::ST_TEMP;
				end
			end
			led_seq_pkg::ST_NODIODE: begin
				state_nxt = led_seq_pkg::ST_NODIODE;
			end
			led_seq_pkg::ST_STOP: begin
				state_nxt = led_seq_pkg::ST_STOP;
			end
			default: begin
				state_nxt = led_seq_pkg::ST_IDLE;
			end
		endcase
		if (!en_s || !supply_s) begin
			state_nxt = led_seq_pkg::ST_IDLE;
		end
	end

	// The on-time ceiling grows each period during soft-start and is lifted in run.
	assign soft_lim_nxt = (state_r == led_seq_pkg::ST_RUN) ? {CW{1'b1}} :
	                      (state_r != led_seq_pkg::ST_SOFT) ? led_seq_pkg::SOFT_START_CYC :
	                      !per_wrap ? soft_lim_r :
	                      soft_sum[CW] ? {CW{1'b1}} : soft_sum[CW-1:0];

	// Switch gating. Peak current and the soft ceiling are ignored before the minimum
	// on-time, so every pulse is at least that long; the last cycle of a period is
	// always off, which bounds the duty cycle when the peak never trips.
	wire end_pulse  = (on_cnt_r >= MIN_ON - 1'b1) && (peak_s || on_cnt_r >= soft_lim_r);
	wire new_pulse  = !skip_s && !ovtrip_s;

	assign switch_nxt  = !run_ok ? 1'b0 :
	                     per_wrap ? new_pulse :
	                     (per_late || end_pulse) ? 1'b0 : switch_on;
	assign on_cnt_nxt  = (switch_nxt && switch_on) ? on_cnt_r + 1'b1 : '0;
	assign per_cnt_nxt = (!run_ok || per_wrap) ? '0 : per_cnt_r + 1'b1;

	// Open strings are caught only when the output reaches the overvoltage point.
	assign mark_open_nxt  = clear_all ? '0 :
	                        mark_open_r | ((switching && ovtrip_s) ? (active & open_s) : '0);
	assign mark_short_nxt = clear_all ? '0 : mark_short_r | (short_exp & active);

	// One fault timer per string; timers only run while the converter switches.
	for (genvar i = 0; i < NUM_STR; i++) begin : g_timer
		short_fault_timer #(
			.LIMIT(FAULT_CYC),
			.TW   (TW)
		) u_timer (
			.mclk     (mclk),
			.sys_rst  (sys_rst),
			.restart  (!switching),
			.short_det(short_s[i]),
			.expired  (short_exp[i])
		);
	end

	// Sequencer and marks.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r      <= led_seq_pkg::ST_IDLE;
			mark_open_r  <= '0;
			mark_short_r <= '0;
		end else begin
			state_r      <= state_nxt;
			mark_open_r  <= mark_open_nxt;
			mark_short_r <= mark_short_nxt;
		end
	end

	// Switching-cycle counters and the power switch itself.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			per_cnt_r  <= '0;
			on_cnt_r   <= '0;
			soft_lim_r <= led_seq_pkg::SOFT_START_CYC;
			switch_on  <= 1'b0;
		end else begin
			per_cnt_r  <= per_cnt_nxt;
			on_cnt_r   <= on_cnt_nxt;
			soft_lim_r <= soft_lim_nxt;
			switch_on  <= switch_nxt;
		end
	end

	// Registered string and status outputs. Marks reach the channels in the same
	// cycle they are set, so a marked string never conducts for an extra cycle.
	wire [NUM_STR-1:0] active_nxt = ~(mark_open_nxt | mark_short_nxt);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			string_on        <= '0;
			feedback_mask    <= '0;
			short_candidate  <= '0;
			converter_active <= 1'b0;
			soft_start_busy  <= 1'b0;
			diode_missing    <= 1'b0;
		end else begin
			string_on        <= run_ok ? (active_nxt & {NUM_STR{dim_s}}) : '0;
			feedback_mask    <= run_ok ? active_nxt : '0;
			short_candidate  <= switching ? (short_s & active) : '0;
			converter_active <= run_ok;
			soft_start_busy  <= (state_nxt == led_seq_pkg::ST_SOFT);
			diode_missing    <= (state_nxt == led_seq_pkg::ST_NODIODE);
		end
	end

	assign marked_open  = mark_open_r;
	assign marked_short = mark_short_r;

	a_no_diode_held: assert property (@(posedge mclk) disable iff (sys_rst)
		(state_r == led_seq_pkg::ST_DIODE && ovlow_s && en_s && supply_s) |=>
		(state_r == led_seq_pkg::ST_NODIODE) ##1 (!switch_on && string_on == '0))
		else $error("missing diode did not hold the device off");

	a_check_order: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(state_r == led_seq_pkg::ST_TEMP) |->
		($past(state_r) == led_seq_pkg::ST_SUPPLY || $past(state_r) == led_seq_pkg::ST_SOFT ||
		 $past(state_r) == led_seq_pkg::ST_RUN))
		else $error("temperature checked out of order");

	a_soft_before_run: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(state_r == led_seq_pkg::ST_RUN) |-> $past(state_r) == led_seq_pkg::ST_SOFT)
		else $error("run entered without soft-start");

	a_lockout_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!supply_s |=> (state_r == led_seq_pkg::ST_IDLE) && !switch_on ##1 string_on == '0)
		else $error("supply lockout did not stop operation");

	a_period_on: assert property (@(posedge mclk) disable iff (sys_rst)
		(run_ok && per_wrap && !skip_s && !ovtrip_s) |=> switch_on && per_cnt_r == '0)
		else $error("switch not turned on at period start");

	a_peak_off: assert property (@(posedge mclk) disable iff (sys_rst)
		(switch_on && peak_s && on_cnt_r >= MIN_ON - 1'b1 && !per_wrap) |=> !switch_on)
		else $error("switch stayed on after peak trip");

	a_min_on_time: assert property (@(posedge mclk) disable iff (sys_rst)
		($fell(switch_on) && $past(run_ok) && !$past(per_wrap)) |->
		$past(on_cnt_r) >= MIN_ON - 1'b1)
		else $error("pulse shorter than minimum on-time");

	a_skip_off: assert property (@(posedge mclk) disable iff (sys_rst)
		(per_wrap && skip_s) |=> !switch_on)
		else $error("pulse issued while skipping");

	a_dim_gate: assert property (@(posedge mclk) disable iff (sys_rst)
		!dim_s |=> string_on == '0)
		else $error("strings conduct while dimming input is low");

	a_marked_dark: assert property (@(posedge mclk) disable iff (sys_rst)
		((string_on | feedback_mask) & (mark_open_r | mark_short_r)) == '0)
		else $error("marked string still on or in feedback");

	a_open_mark: assert property (@(posedge mclk) disable iff (sys_rst)
		(switching && ovtrip_s && state_r != led_seq_pkg::ST_IDLE) |=>
		(mark_open_r & $past(open_s & active)) == $past(open_s & active))
		else $error("open string not marked at overvoltage");

	a_none_left_stop: assert property (@(posedge mclk) disable iff (sys_rst)
		(switching && none_left && en_s && supply_s) |=>
		state_r == led_seq_pkg::ST_STOP ##1 !switch_on)
		else $error("converter kept running with no string left");

	a_marks_kept: assert property (@(posedge mclk) disable iff (sys_rst)
		(state_r != led_seq_pkg::ST_IDLE) |=>
		((mark_open_r | mark_short_r) & $past(mark_open_r | mark_short_r)) ==
		$past(mark_open_r | mark_short_r))
		else $error("mark-off lost before shutdown");

	a_short_mark: assert property (@(posedge mclk) disable iff (sys_rst)
		(|(short_exp & active) && !clear_all) |=>
		(mark_short_r & $past(short_exp & active)) == $past(short_exp & active))
		else $error("expired short not marked off");

	a_short_flag: assert property (@(posedge mclk) disable iff (sys_rst)
		(switching && |(short_s & active)) |=>
		(short_candidate & $past(short_s & active)) == $past(short_s & active))
		else $error("short on an active string not flagged");

	a_feedback_set: assert property (@(posedge mclk) disable iff (sys_rst)
		run_ok |=> feedback_mask == ~(mark_open_r | mark_short_r))
		else $error("active string missing from feedback");

	a_disable_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		!en_s |=> (state_r == led_seq_pkg::ST_IDLE) && !switch_on ##1
		(mark_open_r == '0) && (mark_short_r == '0) && (string_on == '0))
		else $error("disable did not return to idle");

endmodule : led_boost_fault_sequencer

`default_nettype wire

// ===== dv/led_string_model.sv
`timescale 1ns/1ps
`default_nettype none

module led_string_model #(
	parameter int N = 4
) (
	input  wire logic         mclk,
	input  wire logic         dim_run,
	input  wire logic [31:0]  dim_per,
	input  wire logic [31:0]  dim_hi,
	input  wire logic [N-1:0] open_cfg,
	input  wire logic [N-1:0] short_cfg,
	output logic              dim_in,
	output logic      [N-1:0] string_sense_open,
	output logic      [N-1:0] string_sense_short
);
	int cnt;

	// Dimming is already high before enable, so the device never starts dark.
	// The burst restarts in its high phase each time it is switched on and runs at a
	// rate inside the allowed dimming range, so a short run sees only part of a period.
	// The string faults are shown as the comparator flags that they cause.
	initial begin
		cnt = 0;
		dim_in = 1'b1;
		string_sense_open = '0;
		string_sense_short = '0;
		forever begin
			@(negedge mclk);
			cnt = (!dim_run || cnt + 1 >= int'(dim_per)) ? 0 : cnt + 1;
			dim_in <= dim_run ? (cnt < int'(dim_hi)) : 1'b1;
			string_sense_open <= open_cfg;
			string_sense_short <= short_cfg;
		end
	end
endmodule : led_string_model

`default_nettype wire

// ===== dv/led_boost_fault_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module led_boost_fault_sequencer_tb_top;
	localparam int FC = 50;
	logic mclk, sys_rst, enable_pin, freq_select, supply_lockout_ok, temp_ok, dim_in, dim_run;
	logic overvoltage_sense_low, overvoltage_sense_trip, peak_current_trip, skip_request;
	logic switch_on, converter_active, soft_start_busy, diode_missing;
	logic [31:0] dim_per, dim_hi;
	logic [3:0]  open_cfg, short_cfg, string_sense_open, string_sense_short, string_on;
	logic [3:0]  feedback_mask, short_candidate, marked_open, marked_short, exp_open, exp_short;
	int          err_count = 0, tests_run = 0, cyc = 0, w, p, r, hits, split;

	led_boost_fault_sequencer #(.NUM_STR(4), .FAULT_CYC(FC)) dut_u (.mclk, .sys_rst, .enable_pin,
		.freq_select, .dim_in, .supply_lockout_ok, .temp_ok, .overvoltage_sense_low,
		.overvoltage_sense_trip, .string_sense_open, .string_sense_short, .peak_current_trip,
		.skip_request, .switch_on, .string_on, .feedback_mask, .short_candidate, .marked_open,
		.marked_short, .converter_active, .soft_start_busy, .diode_missing);

	led_string_model #(.N(4)) partner_u (.mclk, .dim_run, .dim_per, .dim_hi, .open_cfg,
		.short_cfg, .dim_in, .string_sense_open, .string_sense_short);

	// Free-running clock.
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic print_verdict();
		$display("Checks run %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict

	// A hang is cut short well beyond the expected length of the run.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic tick(input int k);
		repeat (k) @(negedge mclk);
	endtask : tick

	// Measures one switching pulse: cycles on, and cycles from its rise to the next rise.
	task automatic pulse(output int on_c, output int per_c);
		int t;
		t = 0;
		on_c = 0;
		per_c = 0;
		while (switch_on !== 1'b0 && t < 1000) begin
			tick(1);
			t++;
		end
		while (switch_on !== 1'b1 && t < 2000) begin
			tick(1);
			t++;
		end
		while (switch_on === 1'b1 && per_c < 1000) begin
			tick(1);
			on_c++;
			per_c++;
		end
		while (switch_on !== 1'b1 && per_c < 1000) begin
			tick(1);
			per_c++;
		end
	endtask : pulse

	// Bounded wait for switching to be permitted; the check after it catches a miss.
	task automatic wait_active();
		int t;
		t = 0;
		while (converter_active !== 1'b1 && t < 40) begin
			tick(1);
			t++;
		end
	endtask : wait_active

	task automatic restart();
		enable_pin = 1'b0;
		tick(4);
		enable_pin = 1'b1;
		wait_active();
	endtask : restart

	// Main sequence; inputs change on falling edges only.
	initial begin
		sys_rst = 1'b1;
		enable_pin = 1'b0;
		freq_select = 1'b1;
		supply_lockout_ok = 1'b1;
		temp_ok = 1'b1;
		overvoltage_sense_low = 1'b0;
		overvoltage_sense_trip = 1'b0;
		peak_current_trip = 1'b0;
		skip_request = 1'b0;
		dim_run = 1'b0;
		dim_per = 32'h0001e848;
		dim_hi = 32'h000003e8;
		open_cfg = 4'h0;
		short_cfg = 4'h0;
		void'($urandom(32'h5ad2));
		tick(3);
		sys_rst = 1'b0;
		overvoltage_sense_low = 1'b1;
		enable_pin = 1'b1;
		tick(10);
		check("diode_missing", diode_missing, 1);
		check("active_no_diode", converter_active, 0);
		enable_pin = 1'b0;
		overvoltage_sense_low = 1'b0;
		supply_lockout_ok = 1'b0;
		temp_ok = 1'b0;
		tick(4);
		enable_pin = 1'b1;
		tick(10);
		check("active_no_supply", converter_active, 0);
		supply_lockout_ok = 1'b1;
		tick(10);
		check("active_no_temp", converter_active, 0);
		temp_ok = 1'b1;
		wait_active();
		check("soft_start_busy", soft_start_busy, 1);
		pulse(w, p);
		check("soft_on_time", (w >= 25 && w < 40), 1);
		peak_current_trip = 1'b1;
		pulse(w, p);
		check("peak_on_time", (w >= 25 && w <= 28), 1);
		// The soft ceiling needs some 44 fast periods before full drive.
		peak_current_trip = 1'b0;
		tick(9000);
		pulse(w, p);
		check("run_on_time", w, 199);
		check("period_fast", p, 200);
		freq_select = 1'b0;
		tick(20);
		pulse(w, p);
		check("period_slow", p, 400);
		freq_select = 1'b1;
		skip_request = 1'b1;
		// The pulse already under way runs to the end of its period first.
		tick(220);
		hits = 0;
		repeat (900) begin
			tick(1);
			hits += int'(switch_on);
		end
		check("skip_pulses", hits, 0);
		skip_request = 1'b0;
		// The window holds the burst's first high phase and the start of its low phase.
		dim_run = 1'b1;
		tick(10);
		hits = 0;
		split = 0;
		repeat (2000) begin
			tick(1);
			hits += int'(string_on[0]);
			split += int'(string_on !== {4{string_on[0]}});
		end
		check("dim_duty", (hits >= int'(dim_hi) - 20 && hits <= int'(dim_hi)), 1);
		check("dim_together", split, 0);
		dim_run = 1'b0;
		tick(10);
		// A random set of open strings, never all four.
		exp_open = 4'(1 + $urandom % 14);
		open_cfg = exp_open;
		overvoltage_sense_trip = 1'b1;
		tick(8);
		overvoltage_sense_trip = 1'b0;
		open_cfg = 4'h0;
		tick(8);
		check("marked_open", marked_open, exp_open);
		check("feedback_mask", feedback_mask, 4'(~exp_open));
		check("open_strings_on", string_on, 4'(~exp_open));
		r = 0;
		while (exp_open[r]) r++;
		exp_short = 4'h1 << r;
		short_cfg = exp_short;
		tick(10);
		check("short_candidate", short_candidate, exp_short);
		tick(20);
		short_cfg = 4'h0;
		tick(3);
		short_cfg = exp_short;
		tick(30);
		check("short_after_gap", marked_short, 0);
		tick(40);
		check("marked_short", marked_short, exp_short);
		check("short_string_on", string_on & exp_short, 0);
		check("short_feedback", feedback_mask & exp_short, 0);
		short_cfg = 4'h0;
		open_cfg = 4'(~(exp_open | exp_short));
		overvoltage_sense_trip = 1'b1;
		tick(10);
		overvoltage_sense_trip = 1'b0;
		open_cfg = 4'h0;
		tick(4);
		check("stop_all_marked", converter_active, 0);
		check("switch_stopped", switch_on, 0);
		enable_pin = 1'b0;
		tick(6);
		check("marks_cleared", {marked_open, marked_short}, 0);
		check("strings_off", string_on, 0);
		enable_pin = 1'b1;
		wait_active();
		short_cfg = 4'hf;
		tick(70);
		check("all_short", marked_short, 4'hf);
		check("stop_all_short", converter_active, 0);
		short_cfg = 4'h0;
		restart();
		open_cfg = 4'hf;
		overvoltage_sense_trip = 1'b1;
		tick(10);
		check("all_open", marked_open, 4'hf);
		check("stop_all_open", converter_active, 0);
		overvoltage_sense_trip = 1'b0;
		open_cfg = 4'h0;
		restart();
		tick(50);
		supply_lockout_ok = 1'b0;
		tick(5);
		check("lockout_switch", switch_on, 0);
		check("lockout_active", converter_active, 0);
		supply_lockout_ok = 1'b1;
		wait_active();
		check("lockout_resume", converter_active, 1);
		print_verdict();
	end
endmodule : led_boost_fault_sequencer_tb_top

`default_nettype wire
